//--- core/intc_pkg.sv
// Constants, register map and source table of the vectored interrupt priority unit
package intc_pkg;

    // --------------------
    // Source table
    // --------------------
    localparam int             NUM_SOURCES   = 118;
    localparam int             NUM_FLAG_REGS = 8;
    localparam int             NUM_PRIO_REGS = 30;
    localparam int             TRAP_SLOTS    = 8;
    localparam int             VECTOR_BIAS   = 8;
    // Implemented request numbers, reserved ones read zero
    localparam logic [127:0]   IMPLEMENTED   = 128'h0000_0000_0000_0002_0000_0000_20db_3fef;
    localparam int             EXT_IRQ0_NUM  = 0;
    localparam int             EXT_IRQ1_NUM  = 20;
    localparam int             EXT_IRQ2_NUM  = 29;

    // --------------------
    // Vector tables
    // --------------------
    localparam logic [23:0]    RESET_ADDRESS   = 24'h000000;
    localparam logic [23:0]    PRIMARY_BASE    = 24'h000004;
    localparam logic [23:0]    ALTERNATE_BASE  = 24'h000104;
    localparam logic [23:0]    CODE_START      = 24'h000200;

    // --------------------
    // Register byte addresses on the slave bus
    // --------------------
    localparam logic [7:0]     INT_CONTROL_ONE_ADDR = 8'h00;
    localparam logic [7:0]     INT_CONTROL_TWO_ADDR = 8'h04;
    localparam logic [7:0]     PENDING_VECTOR_ADDR  = 8'h08;
    localparam logic [7:0]     CPU_STATUS_ADDR      = 8'h0c;
    localparam logic [7:0]     CORE_CONTROL_ADDR    = 8'h10;
    localparam logic [7:0]     FLAG_BASE_ADDR       = 8'h20;
    localparam logic [7:0]     ENABLE_BASE_ADDR     = 8'h40;
    localparam logic [7:0]     PRIO_BASE_ADDR       = 8'h60;

    // --------------------
    // Field positions and reset values
    // --------------------
    localparam int             NESTING_DISABLE_BIT = 15;
    localparam int             ALT_SELECT_BIT      = 15;
    localparam int             PRIO_LOW_LSB        = 5;
    localparam int             PRIO_MSB_BIT        = 3;
    localparam int             PRIO_STRIDE         = 4;
    localparam logic [15:0]    CONTROL_ONE_MASK    = 16'h801e;
    localparam logic [15:0]    CONTROL_TWO_MASK    = 16'h8007;
    localparam logic [15:0]    REG_RESET           = 16'h0000;
    localparam logic [2:0]     PRIO_LOW_RESET      = 3'h0;
    localparam logic [3:0]     LEVEL_RESET         = 4'h0;
    localparam logic [3:0]     TRAP_LEVEL_TOP      = 4'hf;

endpackage : intc_pkg

//--- core/vectored_interrupt_priority_unit.sv
// Vectored interrupt and trap controller with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module vectored_interrupt_priority_unit (
    input  wire logic                   clock,
    input  wire logic                   reset,
    // Avalon-MM slave
    input  wire logic [7:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // Sources
    input  wire logic [117:0]           source_event,
    input  wire logic [4:1]             trap_event,
    input  wire logic                   ext_irq0,
    input  wire logic                   ext_irq1,
    input  wire logic                   ext_irq2,
    // Core side
    input  wire logic                   core_ack,
    input  wire logic                   core_restore,
    input  wire logic [3:0]             core_restore_level,
    output logic                        core_irq,
    output logic      [6:0]             core_vector_number,
    output logic      [3:0]             core_level,
    output logic      [23:0]            core_vector_address,
    output logic      [3:0]             cpu_priority_level
);

    // --------------------
    // Helpers
    // --------------------
    // Implemented sources, read before the helpers below use it
    localparam logic [127:0] IMPL = intc_pkg::IMPLEMENTED;

    // Byte-lane merge of a 16-bit register, writable bits only
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be,
                                            input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes   = {{8{be[1]}}, {8{be[0]}}} & wmask;
        merge16 = (old_v & ~lanes) | (wdata[15:0] & lanes);
    endfunction : merge16

    // Writable priority bits of one register: implemented sources only
    function automatic logic [15:0] prio_mask(input int k);
        logic [15:0] m;
        m = 16'h0000;
        for (int f = 0; f < 4; f++) begin
            if (IMPL[k * 4 + f]) begin
                m[f * intc_pkg::PRIO_STRIDE +: 3] = 3'h7;
            end
        end
        prio_mask = m;
    endfunction : prio_mask

    // --------------------
    // State
    // --------------------
    logic [7:0][15:0]  flag_q, flag_d;
    logic [7:0][15:0]  enable_q, enable_d;
    logic [29:0][15:0] prio_q, prio_d;
    logic [15:0]       ctl_one_q, ctl_one_d;
    logic [15:0]       ctl_two_q, ctl_two_d;
    logic [2:0]        prio_low_q, prio_low_d;
    logic              prio_msb_q, prio_msb_d;
    logic              wait_q, wait_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              irq_q, irq_d;
    logic [6:0]        pending_vector_number_q, pending_vector_number_d;
    logic [3:0]        level_q, level_d;
    logic [23:0]       vaddr_q, vaddr_d;
    logic [2:0]        ext_meta_q, ext_sync_q, ext_prev_q;
    logic [2:0]        ext_edge;
    logic [127:0]      set_vec;
    logic              bus_write;
    logic [3:0]        cur_level;

    assign cur_level = {prio_msb_q, prio_low_q};
    assign bus_write = write && !wait_q;

    // --------------------
    // External inputs
    // --------------------
    // Two-stage synchroniser, then a history flop for the edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ext_meta_q <= 3'h0;
            ext_sync_q <= 3'h0;
            ext_prev_q <= 3'h0;
        end else begin
            ext_meta_q <= {ext_irq2, ext_irq1, ext_irq0};
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Polarity bit high selects the falling edge
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ext_edge[i] = ctl_two_q[i] ? (ext_prev_q[i] && !ext_sync_q[i])
                                       : (!ext_prev_q[i] && ext_sync_q[i]);
        end
        set_vec                     = {10'h000, source_event};
        set_vec[intc_pkg::EXT_IRQ0_NUM] = source_event[intc_pkg::EXT_IRQ0_NUM] | ext_edge[0];
        set_vec[intc_pkg::EXT_IRQ1_NUM] = source_event[intc_pkg::EXT_IRQ1_NUM] | ext_edge[1];
        set_vec[intc_pkg::EXT_IRQ2_NUM] = source_event[intc_pkg::EXT_IRQ2_NUM] | ext_edge[2];
        set_vec                     = set_vec & IMPL;
    end

    // --------------------
    // Register file next state
    // --------------------
    // Set wins over a software clear in the same cycle
    always_comb begin
        flag_d     = flag_q;
        enable_d   = enable_q;
        prio_d     = prio_q;
        ctl_one_d  = ctl_one_q;
        ctl_two_d  = ctl_two_q;
        prio_low_d = prio_low_q;
        prio_msb_d = prio_msb_q;
        if (bus_write) begin
            for (int k = 0; k < intc_pkg::NUM_FLAG_REGS; k++) begin
                if (address == intc_pkg::FLAG_BASE_ADDR + 8'(k * 4)) begin
                    flag_d[k] = merge16(flag_q[k], writedata, byteenable,
                                        IMPL[k * 16 +: 16]);
                end
                if (address == intc_pkg::ENABLE_BASE_ADDR + 8'(k * 4)) begin
                    enable_d[k] = merge16(enable_q[k], writedata, byteenable,
                                          IMPL[k * 16 +: 16]);
                end
            end
            for (int k = 0; k < intc_pkg::NUM_PRIO_REGS; k++) begin
                if (address == intc_pkg::PRIO_BASE_ADDR + 8'(k * 4)) begin
                    prio_d[k] = merge16(prio_q[k], writedata, byteenable,
                                        prio_mask(k));
                end
            end
            unique case (address)
                intc_pkg::INT_CONTROL_ONE_ADDR: begin
                    ctl_one_d = merge16(ctl_one_q, writedata, byteenable,
                                        intc_pkg::CONTROL_ONE_MASK);
                end
                intc_pkg::INT_CONTROL_TWO_ADDR: begin
                    ctl_two_d = merge16(ctl_two_q, writedata, byteenable,
                                        intc_pkg::CONTROL_TWO_MASK);
                end
                intc_pkg::CPU_STATUS_ADDR: begin
                    // Frozen while nesting is disabled
                    if (!ctl_one_q[intc_pkg::NESTING_DISABLE_BIT] && byteenable[0]) begin
                        prio_low_d = writedata[intc_pkg::PRIO_LOW_LSB +: 3];
                    end
                end
                // Core control write is dropped: msb stays hardware-owned
                default: begin
                    prio_low_d = prio_low_d;
                end
            endcase
        end
        // Hardware sets, ORed after the software write
        for (int k = 0; k < intc_pkg::NUM_FLAG_REGS; k++) begin
            flag_d[k] = flag_d[k] | set_vec[k * 16 +: 16];
        end
        ctl_one_d[4:1] = ctl_one_d[4:1] | trap_event;
        // Core entry raises its level; return restores it
        if (core_ack && irq_q) begin
            prio_low_d = level_q[2:0];
            prio_msb_d = level_q[3];
        end else if (core_restore) begin
            prio_low_d = core_restore_level[2:0];
            prio_msb_d = core_restore_level[3];
        end
    end

    // --------------------
    // Bus answer
    // --------------------
    // One wait cycle per access; read data ready at the answering edge
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if ((read || write) && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = 32'h0000_0000;                // Unmapped reads zero
            for (int k = 0; k < intc_pkg::NUM_FLAG_REGS; k++) begin
                if (address == intc_pkg::FLAG_BASE_ADDR + 8'(k * 4)) begin
                    rdata_d[15:0] = flag_q[k];
                end
                if (address == intc_pkg::ENABLE_BASE_ADDR + 8'(k * 4)) begin
                    rdata_d[15:0] = enable_q[k];
                end
            end
            for (int k = 0; k < intc_pkg::NUM_PRIO_REGS; k++) begin
                if (address == intc_pkg::PRIO_BASE_ADDR + 8'(k * 4)) begin
                    rdata_d[15:0] = prio_q[k];
                end
            end
            unique case (address)
                intc_pkg::INT_CONTROL_ONE_ADDR: rdata_d[15:0] = ctl_one_q;
                intc_pkg::INT_CONTROL_TWO_ADDR: rdata_d[15:0] = ctl_two_q;
                intc_pkg::PENDING_VECTOR_ADDR: begin
                    rdata_d[6:0]  = pending_vector_number_q;
                    rdata_d[11:8] = level_q;
                end
                intc_pkg::CPU_STATUS_ADDR: begin
                    rdata_d[intc_pkg::PRIO_LOW_LSB +: 3] = prio_low_q;
                end
                intc_pkg::CORE_CONTROL_ADDR: begin
                    rdata_d[intc_pkg::PRIO_MSB_BIT] = prio_msb_q;
                end
                default: begin
                    rdata_d = rdata_d;
                end
            endcase
        end
    end

    // --------------------
    // Arbitration
    // --------------------
    // Traps ignore the user mask; user levels never exceed seven
    always_comb begin
        logic [2:0] best_lvl;
        logic [6:0] best_num;
        logic       found;
        logic [2:0] lvl;
        logic       trap_found;
        logic [2:0] trap_slot;
        logic [6:0] vec;
        best_lvl   = 3'h0;
        best_num   = 7'h00;
        found      = 1'b0;
        lvl        = 3'h0;
        trap_found = 1'b0;
        trap_slot  = 3'h0;
        vec        = 7'h00;
        // Strict compare keeps the lowest number on a tie
        for (int n = 0; n < intc_pkg::NUM_SOURCES; n++) begin
            lvl = prio_q[n / 4][(n % 4) * intc_pkg::PRIO_STRIDE +: 3];
            if (IMPL[n] && flag_q[n / 16][n % 16] && enable_q[n / 16][n % 16]
                && lvl > best_lvl) begin
                best_lvl = lvl;
                best_num = 7'(n);
                found    = 1'b1;
            end
        end
        // Lowest trap slot wins; descending walk leaves it last
        for (int s = 4; s >= 1; s--) begin
            if (ctl_one_q[s] && (intc_pkg::TRAP_LEVEL_TOP - 4'(s)) > cur_level) begin
                trap_found = 1'b1;
                trap_slot  = 3'(s);
            end
        end
        found = found && ({1'b0, best_lvl} > cur_level);
        irq_d    = (trap_found || found) && !core_ack;
        pending_vector_number_d = pending_vector_number_q;
        level_d  = level_q;
        if (trap_found) begin
            vec     = {4'h0, trap_slot};
            level_d = intc_pkg::TRAP_LEVEL_TOP - {1'b0, trap_slot};
        end else if (found) begin
            vec     = best_num + 7'(intc_pkg::VECTOR_BIAS);
            level_d = {1'b0, best_lvl};
        end
        if (trap_found || found) begin
            pending_vector_number_d = vec;
        end
        // Slot address: table base plus two bytes per vector
        vaddr_d = (ctl_two_q[intc_pkg::ALT_SELECT_BIT] ? intc_pkg::ALTERNATE_BASE
                                                       : intc_pkg::PRIMARY_BASE)
                  + {16'h0000, pending_vector_number_d, 1'b0};
    end

    // --------------------
    // Registers
    // --------------------
    // Every register cleared on reset except wait_q, which is set
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flag_q     <= '0;
            enable_q   <= '0;
            prio_q     <= '0;
            ctl_one_q  <= intc_pkg::REG_RESET;
            ctl_two_q  <= intc_pkg::REG_RESET;
            prio_low_q <= intc_pkg::PRIO_LOW_RESET;
            prio_msb_q <= 1'b0;
            wait_q     <= 1'b1;
            rdata_q    <= 32'h0000_0000;
            irq_q      <= 1'b0;
            pending_vector_number_q   <= 7'h00;
            level_q    <= intc_pkg::LEVEL_RESET;
            vaddr_q    <= intc_pkg::RESET_ADDRESS;
        end else begin
            flag_q     <= flag_d;
            enable_q   <= enable_d;
            prio_q     <= prio_d;
            ctl_one_q  <= ctl_one_d;
            ctl_two_q  <= ctl_two_d;
            prio_low_q <= prio_low_d;
            prio_msb_q <= prio_msb_d;
            wait_q     <= wait_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
            pending_vector_number_q   <= pending_vector_number_d;
            level_q    <= level_d;
            vaddr_q    <= vaddr_d;
        end
    end

    // Outputs straight from flops
    assign readdata            = rdata_q;
    assign waitrequest         = wait_q;
    assign core_irq            = irq_q;
    assign core_vector_number  = pending_vector_number_q;
    assign core_level          = level_q;
    assign core_vector_address = vaddr_q;
    assign cpu_priority_level  = {prio_msb_q, prio_low_q};

endmodule : vectored_interrupt_priority_unit

//--- bench/intc_checker.sv
// Port-level assertions for the vectored interrupt unit
`timescale 1ns/1ps
module intc_checker (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest,
    input wire logic        core_ack,
    input wire logic        core_restore,
    input wire logic [3:0]  core_restore_level,
    input wire logic        core_irq,
    input wire logic [6:0]  core_vector_number,
    input wire logic [3:0]  core_level,
    input wire logic [23:0] core_vector_address,
    input wire logic [3:0]  cpu_priority_level
);
    // --------------------
    // Single clock domain, so one default clocking serves all
    // --------------------
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (reset);

    property p_bus_answer;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    property p_reset_clear;
        $past(reset) |-> cpu_priority_level == 4'h0 && !core_irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");

    property p_ack_level;
        core_irq && core_ack |=> !core_irq && cpu_priority_level == $past(core_level);
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("ack did not load level");

    property p_restore;
        core_restore && !core_ack |=> cpu_priority_level == $past(core_restore_level);
    endproperty
    a_restore: assert property (p_restore) else $error("restore level not loaded");

    // Slot address is base plus two bytes per vector, in either table
    property p_slot_address;
        core_irq |-> core_vector_address[7:0] == 8'h04 + {core_vector_number, 1'b0}
            && core_vector_address[23:9] == 15'h0000;
    endproperty
    a_slot_address: assert property (p_slot_address) else $error("bad slot address");

    property p_above_core;
        $rose(core_irq) && $stable(cpu_priority_level) |-> core_level > cpu_priority_level;
    endproperty
    a_above_core: assert property (p_above_core) else $error("request not above core");

    property p_user_blocked;
        $rose(core_irq) && $stable(cpu_priority_level) && cpu_priority_level >= 4'h7
            |-> core_vector_number < 7'd8;
    endproperty
    a_user_blocked: assert property (p_user_blocked) else $error("user source not blocked");

    property p_msb_locked;
        write && !waitrequest && address == intc_pkg::CORE_CONTROL_ADDR && !core_ack
            && !core_restore |=> $stable(cpu_priority_level);
    endproperty
    a_msb_locked: assert property (p_msb_locked) else $error("level msb was written");
endmodule : intc_checker

bind vectored_interrupt_priority_unit intc_checker checker_inst (
    .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
    .waitrequest(waitrequest), .core_ack(core_ack), .core_restore(core_restore),
    .core_restore_level(core_restore_level), .core_irq(core_irq),
    .core_vector_number(core_vector_number), .core_level(core_level),
    .core_vector_address(core_vector_address), .cpu_priority_level(cpu_priority_level));

//--- bench/core_model.sv
// Behavioural processor core that takes requests and returns
`timescale 1ns/1ps
module core_model (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        ack_enable,
    input wire logic        restore_go,
    input wire logic        core_irq,
    input wire logic [23:0] core_vector_address,
    input wire logic [3:0]  cpu_priority_level,
    output logic            core_ack,
    output logic            core_restore,
    output logic [3:0]      core_restore_level,
    output logic [23:0]     handler_pc
);
    logic [1:0] wait_q;
    logic [3:0] saved_q;

    // Slow core: takes a standing request only on its third cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            core_ack <= 1'b0;
            core_restore <= 1'b0;
            core_restore_level <= 4'h0;
            handler_pc <= 24'h000000;
            wait_q <= 2'h0;
            saved_q <= 4'h0;
        end else begin
            core_ack <= 1'b0;
            core_restore <= restore_go;
            core_restore_level <= saved_q;
            if (ack_enable && core_irq && !core_ack) begin
                wait_q <= wait_q + 2'h1;
                if (wait_q == 2'h2) begin
                    core_ack <= 1'b1;
                    handler_pc <= core_vector_address;
                    saved_q <= cpu_priority_level;
                    wait_q <= 2'h0;
                end
            end
        end
    end
endmodule : core_model

//--- bench/tb_top.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`define CHECK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, e, a); end end
module tb_top;
    localparam logic [7:0] one_adr  = intc_pkg::INT_CONTROL_ONE_ADDR;
    localparam logic [7:0] two_adr  = intc_pkg::INT_CONTROL_TWO_ADDR;
    localparam logic [7:0] stat_adr = intc_pkg::CPU_STATUS_ADDR;
    localparam logic [7:0] flag_adr = intc_pkg::FLAG_BASE_ADDR;
    localparam logic [7:0] en_adr   = intc_pkg::ENABLE_BASE_ADDR;
    localparam logic [7:0] prio_adr = intc_pkg::PRIO_BASE_ADDR;
    logic clock, reset, read, write, waitrequest, ext_irq0, ext_irq1, ext_irq2;
    logic core_ack, core_restore, core_irq, ack_enable, restore_go;
    logic [7:0]   address;
    logic [31:0]  writedata, readdata;
    logic [117:0] source_event;
    logic [4:1]   trap_event;
    logic [3:0]   core_restore_level, core_level, cpu_priority_level;
    logic [6:0]   core_vector_number;
    logic [23:0]  core_vector_address, handler_pc;
    logic [15:0]  rd;
    int           fails, checked;

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    vectored_interrupt_priority_unit vectored_interrupt_priority_unit_inst (
        .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
        .waitrequest(waitrequest), .source_event(source_event), .trap_event(trap_event),
        .ext_irq0(ext_irq0), .ext_irq1(ext_irq1), .ext_irq2(ext_irq2), .core_ack(core_ack),
        .core_restore(core_restore), .core_restore_level(core_restore_level),
        .core_irq(core_irq), .core_vector_number(core_vector_number), .core_level(core_level),
        .core_vector_address(core_vector_address), .cpu_priority_level(cpu_priority_level));
    core_model core_model_inst (
        .clock(clock), .reset(reset), .ack_enable(ack_enable), .restore_go(restore_go),
        .core_irq(core_irq), .core_vector_address(core_vector_address),
        .cpu_priority_level(cpu_priority_level), .core_ack(core_ack),
        .core_restore(core_restore), .core_restore_level(core_restore_level),
        .handler_pc(handler_pc));

    // --------------------
    // Bus and timing helpers
    // --------------------
    // Request holds to the edge that samples waitrequest low; a hang is the watchdog's
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        writedata <= {16'h0000, d};
        read <= !wr;
        write <= wr;
        #1;
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        rd = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
        #1;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string nm);
        bus(1'b0, a, 16'h0000);
        `CHECK(nm, e, rd)
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic pulse(input logic [117:0] m);
        @(posedge clock);
        source_event <= m;
        @(posedge clock);
        source_event <= '0;
    endtask : pulse
    // Bounded wait, a missing request shows up in the next compare
    task automatic wait_irq();
        for (int n = 0; n < 30 && core_irq !== 1'b1; n++) begin
            idle(1);
        end
    endtask : wait_irq
    task automatic ret();
        restore_go = 1'b1;
        idle(1);
        restore_go = 1'b0;
        idle(3);
    endtask : ret

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        rdchk(stat_adr, 16'h0000, "status");
        rdchk(intc_pkg::CORE_CONTROL_ADDR, 16'h0000, "core_ctl");
        rdchk(8'h1c, 16'h0000, "unmapped");
    endtask : t_reset
    task automatic t_single();
        bus(1'b1, prio_adr, 16'h5000);
        bus(1'b1, en_adr, 16'h0008);
        pulse(118'h8);
        wait_irq();
        `CHECK("vector", 7'd11, core_vector_number)
        `CHECK("level", 4'h5, core_level)
        `CHECK("address", 24'h00001a, core_vector_address)
        rdchk(intc_pkg::PENDING_VECTOR_ADDR, 16'h050b, "pending");
        ack_enable = 1'b1;
        idle(8);
        `CHECK("handler", 24'h00001a, handler_pc)
        `CHECK("cpu_level", 4'h5, cpu_priority_level)
        rdchk(flag_adr, 16'h0008, "flag_kept");
        bus(1'b1, flag_adr, 16'h0000);
        ret();
        ack_enable = 1'b0;
        `CHECK("cpu_level", 4'h0, cpu_priority_level)
    endtask : t_single
    task automatic t_order();
        bus(1'b1, prio_adr, 16'h0440);
        bus(1'b1, prio_adr + 8'h0c, 16'h0060);
        bus(1'b1, en_adr, 16'h2006);
        pulse(118'h2006);
        wait_irq();
        `CHECK("vector", 7'd21, core_vector_number)
        bus(1'b1, flag_adr, 16'h0006);
        idle(3);
        `CHECK("vector", 7'd9, core_vector_number)
        `CHECK("address", 24'h000016, core_vector_address)
        bus(1'b1, flag_adr, 16'h0000);
        idle(3);
        `CHECK("irq", 1'b0, core_irq)
    endtask : t_order
    task automatic t_mask();
        bus(1'b1, en_adr, 16'h0000);
        pulse(118'h2);
        idle(8);
        `CHECK("irq", 1'b0, core_irq)
        rdchk(flag_adr, 16'h0002, "flag");
        bus(1'b1, stat_adr, 16'h00e0);
        bus(1'b1, en_adr, 16'h0002);
        idle(8);
        `CHECK("irq", 1'b0, core_irq)
        bus(1'b1, intc_pkg::CORE_CONTROL_ADDR, 16'h0008);
        `CHECK("cpu_level", 4'h7, cpu_priority_level)
        bus(1'b1, one_adr, 16'h8000);
        bus(1'b1, stat_adr, 16'h0000);
        `CHECK("cpu_level", 4'h7, cpu_priority_level)
        bus(1'b1, one_adr, 16'h0000);
        bus(1'b1, stat_adr, 16'h0000);
        wait_irq();
        `CHECK("vector", 7'd9, core_vector_number)
        bus(1'b1, flag_adr, 16'h0000);
    endtask : t_mask
    // Trap under level 7 with the alternate table, then msb masking
    task automatic t_trap();
        bus(1'b1, stat_adr, 16'h00e0);
        bus(1'b1, two_adr, 16'h8000);
        @(posedge clock);
        trap_event <= 4'b0010;
        @(posedge clock);
        trap_event <= 4'b0000;
        wait_irq();
        `CHECK("vector", 7'd2, core_vector_number)
        `CHECK("address", 24'h000108, core_vector_address)
        ack_enable = 1'b1;
        idle(8);
        `CHECK("cpu_level", 4'hd, cpu_priority_level)
        pulse(118'h2);
        idle(8);
        `CHECK("irq", 1'b0, core_irq)
        bus(1'b1, one_adr, 16'h0000);
        bus(1'b1, flag_adr, 16'h0000);
        bus(1'b1, en_adr, 16'h0000);
        ret();
        ack_enable = 1'b0;
        `CHECK("cpu_level", 4'h7, cpu_priority_level)
        bus(1'b1, two_adr, 16'h0000);
        bus(1'b1, stat_adr, 16'h0000);
    endtask : t_trap
    task automatic t_sources();
        pulse(118'h10 | (118'h1 << 65));
        rdchk(flag_adr, 16'h0000, "reserved");
        rdchk(flag_adr + 8'h10, 16'h0002, "flag65");
        bus(1'b1, two_adr, 16'h0004);
        @(posedge clock);
        ext_irq1 <= 1'b1;
        ext_irq2 <= 1'b1;
        idle(8);
        rdchk(flag_adr + 8'h04, 16'h0010, "ext1");
        @(posedge clock);
        ext_irq2 <= 1'b0;
        idle(8);
        rdchk(flag_adr + 8'h04, 16'h2010, "ext2_fall");
        @(posedge clock);
        ext_irq1 <= 1'b0;
    endtask : t_sources

    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Whole run is a few hundred cycles; this is ample
    initial begin
        #200000;
        fails++;
        results();
    end
    initial begin
        {read, write, ext_irq0, ext_irq1, ext_irq2, ack_enable, restore_go} = '0;
        {address, writedata, source_event, trap_event} = '0;
        fails = 0;
        checked = 0;
        reset = 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_order();
        t_mask();
        t_trap();
        t_sources();
        results();
    end
endmodule : tb_top
